// ### chain_ctl_params.svh
/*
  Offsets, field positions, reset values and fixed values of the command
  chain state controller. Assumes inclusion by bare name, once per file.
*/
`ifndef CHAIN_CTL_PARAMS_SVH
`define CHAIN_CTL_PARAMS_SVH

// Register byte offsets on the AXI4-Lite port
`define CTRL_OFFS 12'h000
`define STAT_OFFS 12'h004
`define RESP_OFFS 12'h008
`define DRV_OFFS 12'h00c

// Control register fields
`define CTRL_RUN_BIT 0
`define CTRL_STEP_BIT 1
`define CTRL_CNT_LSB 8
`define CNT_W 8

// Status register fields
`define STAT_DONE_BIT 0
`define STAT_PAUSED_BIT 1
`define STAT_STOPPED_BIT 2
`define STAT_LEGACY_BIT 3
`define STAT_CHAIN_BIT 4
`define STAT_UIRQ_BIT 5
`define STAT_PERR_BIT 6
`define STAT_PEND_BIT 7
`define STAT_CNT_LSB 8
`define STAT_STATE_LSB 16

// Block response byte fields
`define RSP_DONE_BIT 0
`define RSP_REL_BIT 1
`define RSP_IGN_BIT 2
`define RSP_DEVERR_BIT 3
`define RSP_SPUR_BIT 4
`define RSP_DEFICIT_BIT 5
`define RSP_EXCESS_BIT 6
`define RSP_INCONS_BIT 7

// Fixed values
`define DRV_BUSY_VAL 8'h80
`define CNT_RESET 8'h00
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

`endif

// ### chain_ctl_pkg.sv
/*
  Types of the command chain state controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package chain_ctl_pkg;

  typedef enum logic [3:0] {
    ST_LEGACY_IDLE = 4'b0001,
    ST_CHAINED_IDLE = 4'b0010,
    ST_RUN = 4'b0100,
    ST_PAUSED = 4'b1000
  } adapter_state_t;

endpackage

// ### pin_sync3.sv
/*
  Three-stage synchroniser for asynchronous pins, with an agreement filter.
  Assumes the pins are quasi-static compared with sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 #(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          lvl_q <= 1'b0;
        end else begin
          s1_q <= pin_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // Only a settled value is passed on
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end
      assign level_out[i] = lvl_q;
    end
  endgenerate

endmodule

`default_nettype wire

// ### chain_ctl.sv
/*
  Operational state controller of a chained-command disk host adapter:
  four states, single-step and continuous execution, block countdown,
  status and interrupt flags, error capture, AXI4-Lite register slave.
  Assumes the fetch/transfer engine reports block completion and errors
  as one-cycle pulses on sys_clk; drive status pins are asynchronous.
*/
// Behaviour
// - Go cleared while idle clears chain and parity error flags
// - Go cleared ignored unless idle or paused
// - Exactly one of four states held
// - Single-step holds after block; continuous runs on
// - Reset, abort or error enter legacy idle
// - Legacy idle: stopped and legacy flags set
// - Go set with clean flags starts run
// - Chained idle: stopped set, paused/legacy clear
// - Chained idle: drive reads busy, writes dropped
// - Chained idle: go cleared goes legacy idle
// - Run: flags clear, work only here
// - Run executes blocks while count and allowed
// - Block end: response, done, irq, countdown
// - Single-step without pending execute pauses
// - Run error: response bit, chain error, legacy
// - Countdown zero without error: chained idle
// - Paused: paused set, stopped/legacy clear
// - Status read while paused resumes run
// - Bus errors only in status register
// - After error refuse go until status read
// - Drive error bit: device error, legacy idle
// - Status read clears done and interrupt
// - Done interrupts only if block enables
`timescale 1ns/1ps
`default_nettype none
`include "chain_ctl_params.svh"

module chain_ctl
  import chain_ctl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic block_done,
  input wire logic [2:0] block_resp_bits,
  input wire logic block_irq_enable,
  input wire logic spurious_irq_evt,
  input wire logic inconsistency_evt,
  input wire logic length_deficit_evt,
  input wire logic length_excess_evt,
  input wire logic bus_error_evt,
  input wire logic unexpected_irq_evt,
  input wire logic drive_err_pin,
  input wire logic drive_intrq_pin,
  input wire logic [7:0] drive_rd_data,
  output logic run_work,
  output logic host_interrupt_out,
  output logic [7:0] block_resp_byte,
  output logic block_resp_strobe,
  output logic drive_wr_strobe,
  output logic [7:0] drive_wr_data,
  output logic drive_regs_direct
);

  adapter_state_t state_q;
  logic [`CNT_W-1:0] block_countdown_q;
  logic [`CNT_W-1:0] block_count_setting_q;
  logic run_request_bit_q;
  logic single_step_enable_q;
  logic execute_pending_q;
  logic completion_flag_q;
  logic chain_error_flag_q;
  logic bus_parity_error_flag_q;
  logic unexpected_irq_flag_q;
  logic err_lock_q;
  logic [11:0] aw_addr_q;
  logic aw_have_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_have_q;
  logic [1:0] drive_sync;

  pin_sync3 #(.WIDTH(2)) u_pin_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pin_in({drive_intrq_pin, drive_err_pin}),
    .level_out(drive_sync)
  );

  logic drive_err;
  logic drive_intrq;
  assign drive_err = drive_sync[0];
  assign drive_intrq = drive_sync[1];

  function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] offs);
    addr_is = (addr[11:2] == offs[11:2]);
  endfunction

  // Bus handshakes and decoded register events
  logic wr_do;
  logic rd_do;
  logic stat_rd;
  logic ctrl_wr;
  logic go_wr1;
  logic go_wr0;
  logic is_idle;
  assign wr_do = aw_have_q && w_have_q && !s_axi_bvalid;
  assign rd_do = s_axi_arvalid && s_axi_arready;
  assign stat_rd = rd_do && addr_is(s_axi_araddr, `STAT_OFFS);
  assign ctrl_wr = wr_do && addr_is(aw_addr_q, `CTRL_OFFS) && w_strb_q[0];
  assign go_wr1 = ctrl_wr && w_data_q[`CTRL_RUN_BIT];
  assign go_wr0 = ctrl_wr && !w_data_q[`CTRL_RUN_BIT];
  assign is_idle = (state_q == ST_LEGACY_IDLE) || (state_q == ST_CHAINED_IDLE);

  // Block errors go to the response byte; run errors add bus errors
  logic blk_err;
  logic run_err;
  logic start_ok;
  assign blk_err = drive_err || spurious_irq_evt || inconsistency_evt || length_deficit_evt || length_excess_evt;
  assign run_err = (state_q == ST_RUN) && (blk_err || bus_error_evt);
  assign start_ok = !completion_flag_q && !chain_error_flag_q && !unexpected_irq_flag_q && !bus_parity_error_flag_q &&
                    !err_lock_q;

  // Write address / data capture, either order
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 12'h000;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_do) begin
      aw_have_q <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_do) begin
      w_have_q <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (addr_is(aw_addr_q, `CTRL_OFFS) || addr_is(aw_addr_q, `STAT_OFFS) ||
                      addr_is(aw_addr_q, `RESP_OFFS) || addr_is(aw_addr_q, `DRV_OFFS)) ? `AXI_OKAY : `AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register; go and step live here, count in bits 15:8
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_request_bit_q <= 1'b0;
      single_step_enable_q <= 1'b0;
    end else if (ctrl_wr) begin
      run_request_bit_q <= w_data_q[`CTRL_RUN_BIT];
      single_step_enable_q <= w_data_q[`CTRL_STEP_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      block_count_setting_q <= `CNT_RESET;
    end else if (wr_do && addr_is(aw_addr_q, `CTRL_OFFS) && w_strb_q[1]) begin
      block_count_setting_q <= w_data_q[`CTRL_CNT_LSB +: `CNT_W];
    end
  end

  // Operational state machine; error is tested first
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_LEGACY_IDLE;
    end else begin
      case (state_q)
        ST_LEGACY_IDLE: begin
          if (go_wr1 && start_ok) begin
            state_q <= ST_RUN;
          end
        end
        ST_CHAINED_IDLE: begin
          if (go_wr1 && start_ok) begin
            state_q <= ST_RUN;
          end else if (go_wr0) begin
            state_q <= ST_LEGACY_IDLE;
          end
        end
        ST_RUN: begin
          // Clearing go while running is not an abort point
          if (run_err) begin
            state_q <= ST_LEGACY_IDLE;
          end else if (block_done) begin
            state_q <= ST_RUN;
          end else if (block_countdown_q == `CNT_RESET) begin
            state_q <= ST_CHAINED_IDLE;
          end else if (single_step_enable_q && !execute_pending_q) begin
            state_q <= ST_PAUSED;
          end
        end
        ST_PAUSED: begin
          if (go_wr0) begin
            state_q <= ST_LEGACY_IDLE;
          end else if (stat_rd) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_LEGACY_IDLE;
        end
      endcase
    end
  end

  // Block countdown and execute-pending
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      block_countdown_q <= `CNT_RESET;
      execute_pending_q <= 1'b0;
    end else if (is_idle && go_wr1 && start_ok) begin
      block_countdown_q <= block_count_setting_q;
      execute_pending_q <= 1'b1;
    end else if ((state_q == ST_RUN) && block_done && !run_err) begin
      block_countdown_q <= block_countdown_q - 8'h01;
      execute_pending_q <= 1'b0;
    end else if ((state_q == ST_PAUSED) && stat_rd && !go_wr0) begin
      execute_pending_q <= 1'b1;
    end
  end

  // Work permission to the fetch/transfer engine
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_work <= 1'b0;
    end else begin
      run_work <= (state_q == ST_RUN) && !run_err && !block_done && (block_countdown_q != `CNT_RESET) &&
                  (!single_step_enable_q || execute_pending_q);
    end
  end

  // Completion flag: a new completion beats the clearing read
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      completion_flag_q <= 1'b0;
    end else if ((state_q == ST_RUN) && block_done && !run_err) begin
      completion_flag_q <= 1'b1;
    end else if (stat_rd) begin
      completion_flag_q <= 1'b0;
    end
  end

  // Error flags; set wins over every clear
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      chain_error_flag_q <= 1'b0;
      bus_parity_error_flag_q <= 1'b0;
      unexpected_irq_flag_q <= 1'b0;
      err_lock_q <= 1'b0;
    end else begin
      if ((state_q == ST_RUN) && blk_err) begin
        chain_error_flag_q <= 1'b1;
      end else if (is_idle && go_wr0) begin
        chain_error_flag_q <= 1'b0;
      end
      if (bus_error_evt) begin
        bus_parity_error_flag_q <= 1'b1;
      end else if ((is_idle && go_wr0) || stat_rd) begin
        bus_parity_error_flag_q <= 1'b0;
      end
      if (unexpected_irq_evt) begin
        unexpected_irq_flag_q <= 1'b1;
      end else if (stat_rd) begin
        unexpected_irq_flag_q <= 1'b0;
      end
      if (run_err) begin
        err_lock_q <= 1'b1;
      end else if (stat_rd) begin
        err_lock_q <= 1'b0;
      end
    end
  end

  // Host interrupt: level, dropped by the status read
  logic irq_set;
  assign irq_set = ((state_q == ST_RUN) && block_done && !run_err && block_irq_enable) ||
                   run_err || bus_error_evt || unexpected_irq_evt ||
                   ((state_q == ST_RUN) && !run_err && !block_done && (block_countdown_q != `CNT_RESET) &&
                    single_step_enable_q && !execute_pending_q) ||
                   ((state_q == ST_LEGACY_IDLE) && drive_intrq);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      host_interrupt_out <= 1'b0;
    end else if (irq_set) begin
      host_interrupt_out <= 1'b1;
    end else if (stat_rd) begin
      host_interrupt_out <= 1'b0;
    end
  end

  // Response byte; a bus error leaves the block untouched
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      block_resp_byte <= 8'h00;
      block_resp_strobe <= 1'b0;
    end else begin
      block_resp_strobe <= (state_q == ST_RUN) && (blk_err || block_done);
      if ((state_q == ST_RUN) && (blk_err || block_done)) begin
        block_resp_byte[`RSP_DONE_BIT] <= block_resp_bits[0];
        block_resp_byte[`RSP_REL_BIT] <= block_resp_bits[1];
        block_resp_byte[`RSP_IGN_BIT] <= block_resp_bits[2];
        block_resp_byte[`RSP_DEVERR_BIT] <= drive_err;
        block_resp_byte[`RSP_SPUR_BIT] <= spurious_irq_evt;
        block_resp_byte[`RSP_DEFICIT_BIT] <= length_deficit_evt;
        block_resp_byte[`RSP_EXCESS_BIT] <= length_excess_evt;
        block_resp_byte[`RSP_INCONS_BIT] <= inconsistency_evt;
      end
    end
  end

  // Drive register window: direct only in legacy idle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_wr_strobe <= 1'b0;
      drive_wr_data <= 8'h00;
      drive_regs_direct <= 1'b1;
    end else begin
      drive_regs_direct <= (state_q == ST_LEGACY_IDLE);
      drive_wr_strobe <= wr_do && addr_is(aw_addr_q, `DRV_OFFS) && w_strb_q[0] &&
                         (state_q == ST_LEGACY_IDLE);
      if (wr_do && addr_is(aw_addr_q, `DRV_OFFS)) begin
        drive_wr_data <= w_data_q[7:0];
      end
    end
  end

  // Status word, mode flags follow the state directly
  logic [31:0] stat_word;
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`STAT_DONE_BIT] = completion_flag_q;
    stat_word[`STAT_PAUSED_BIT] = (state_q == ST_PAUSED);
    stat_word[`STAT_STOPPED_BIT] = is_idle;
    stat_word[`STAT_LEGACY_BIT] = (state_q == ST_LEGACY_IDLE);
    stat_word[`STAT_CHAIN_BIT] = chain_error_flag_q;
    stat_word[`STAT_UIRQ_BIT] = unexpected_irq_flag_q;
    stat_word[`STAT_PERR_BIT] = bus_parity_error_flag_q;
    stat_word[`STAT_PEND_BIT] = execute_pending_q;
    stat_word[`STAT_CNT_LSB +: `CNT_W] = block_countdown_q;
    stat_word[`STAT_STATE_LSB +: 4] = state_q;
  end

  // Read channel; one read outstanding
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AXI_OKAY;
    end else if (rd_do) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `AXI_OKAY;
      if (addr_is(s_axi_araddr, `CTRL_OFFS)) begin
        s_axi_rdata <= {16'h0000, block_count_setting_q, 6'h00, single_step_enable_q, run_request_bit_q};
      end else if (addr_is(s_axi_araddr, `STAT_OFFS)) begin
        s_axi_rdata <= stat_word;
      end else if (addr_is(s_axi_araddr, `RESP_OFFS)) begin
        s_axi_rdata <= {24'h00_0000, block_resp_byte};
      end else if (addr_is(s_axi_araddr, `DRV_OFFS)) begin
        s_axi_rdata <= {24'h00_0000, (state_q == ST_LEGACY_IDLE) ? drive_rd_data : `DRV_BUSY_VAL};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `AXI_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Host side of recovery is assumed: go is cleared before restart

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_drv_rd_chained;
    rd_do && addr_is(s_axi_araddr, `DRV_OFFS) && (state_q == ST_CHAINED_IDLE);
  endsequence

  sequence s_busy_answer;
    s_axi_rvalid && (s_axi_rdata[7:0] == `DRV_BUSY_VAL);
  endsequence

  a_state_onehot: assert property ($onehot(state_q)) else $error("state not one-hot");
  a_idle_go_clear: assert property (is_idle && go_wr0 && !bus_error_evt |=>
    !chain_error_flag_q && !bus_parity_error_flag_q) else $error("idle go clear kept error");
  a_run_no_abort: assert property ((state_q == ST_RUN) && go_wr0 && !run_err && !block_done &&
    (block_countdown_q != `CNT_RESET) |=> state_q != ST_LEGACY_IDLE) else $error("run aborted by go clear");
  a_start_loads: assert property (is_idle && go_wr1 && start_ok |=> (state_q == ST_RUN) &&
    execute_pending_q && (block_countdown_q == $past(block_count_setting_q))) else $error("start did not load");
  a_block_end: assert property ((state_q == ST_RUN) && block_done && !run_err |=> completion_flag_q &&
    !execute_pending_q && (block_countdown_q == $past(block_countdown_q) - 8'h01)) else $error("block end");
  a_step_pause: assert property ((state_q == ST_RUN) && single_step_enable_q && !execute_pending_q &&
    !run_err && !block_done && (block_countdown_q != `CNT_RESET) |=> state_q == ST_PAUSED) else $error("no pause");
  a_error_exit: assert property (run_err |=> (state_q == ST_LEGACY_IDLE) && host_interrupt_out && err_lock_q)
    else $error("error exit");
  a_count_zero: assert property ((state_q == ST_RUN) && !run_err && !block_done &&
    (block_countdown_q == `CNT_RESET) |=> state_q == ST_CHAINED_IDLE) else $error("count zero");
  a_pause_resume: assert property ((state_q == ST_PAUSED) && stat_rd && !go_wr0 |=>
    (state_q == ST_RUN) && execute_pending_q) else $error("no resume");
  a_lock_refuse: assert property (err_lock_q && !stat_rd && go_wr1 |=> state_q == ST_LEGACY_IDLE)
    else $error("go taken while locked");
  a_drv_busy_read: assert property (s_drv_rd_chained |=> s_busy_answer) else $error("busy value");
  a_bus_err_resp: assert property ((state_q == ST_RUN) && bus_error_evt && !blk_err && !block_done |=>
    !block_resp_strobe && bus_parity_error_flag_q) else $error("bus error in block");
  a_done_no_irq: assert property ((state_q == ST_RUN) && block_done && !block_irq_enable && !irq_set &&
    !host_interrupt_out |=> !host_interrupt_out) else $error("masked done interrupted");
  a_status_clear: assert property (stat_rd && !irq_set |=> !host_interrupt_out) else $error("irq kept");

endmodule

`default_nettype wire

// ### engine_drive_model.sv
/*
  Model of the fetch/transfer engine and drive beside the controller.
  Assumes run_work as a level and one-cycle pulses back on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module engine_drive_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic run_work,
  input wire logic slow,
  input wire logic fail,
  output logic block_done,
  output logic [2:0] block_resp_bits,
  output logic block_irq_enable,
  output logic inconsistency_evt,
  output logic drive_err_pin,
  output logic drive_intrq_pin,
  output logic [7:0] drive_rd_data
);
  logic [7:0] cnt_q;
  logic hold_q;
  assign block_resp_bits = 3'h1;
  // Slow blocks ask for an interrupt, fast ones leave it masked
  assign block_irq_enable = slow;
  assign drive_err_pin = 1'b0;
  assign drive_intrq_pin = 1'b0;
  assign drive_rd_data = 8'h5a;
  // Hold after a pulse: run_work only drops the cycle after it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 8'h00;
      hold_q <= 1'b0;
      block_done <= 1'b0;
      inconsistency_evt <= 1'b0;
    end else begin
      block_done <= 1'b0;
      inconsistency_evt <= 1'b0;
      if (!run_work) begin
        cnt_q <= 8'h00;
        hold_q <= 1'b0;
      end else if (!hold_q && cnt_q == (slow ? 8'h28 : 8'h03)) begin
        hold_q <= 1'b1;
        block_done <= !fail;
        inconsistency_evt <= fail;
      end else if (!hold_q) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb_top.sv
/*
  Self-checking bench of the chain controller over AXI4-Lite.
  Assumes chain_ctl, its package, header and the engine model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "chain_ctl_params.svh"

module tb_top;
  logic sys_clk = 0, rst_b = 0, slow = 0, fail = 0, bus_err = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, d;
  logic [1:0] r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic block_done, block_irq_enable, inconsistency_evt, drive_err_pin, drive_intrq_pin;
  logic run_work, host_interrupt_out, block_resp_strobe, drive_regs_direct;
  logic [2:0] block_resp_bits;
  logic [7:0] drive_rd_data, block_resp_byte;
  int bad_count = 0, comparisons = 0, cyc = 0;

  chain_ctl i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(rready),
    .block_done(block_done), .block_resp_bits(block_resp_bits), .block_irq_enable(block_irq_enable),
    .spurious_irq_evt(1'b0), .inconsistency_evt(inconsistency_evt), .length_deficit_evt(1'b0),
    .length_excess_evt(1'b0), .bus_error_evt(bus_err), .unexpected_irq_evt(1'b0),
    .drive_err_pin(drive_err_pin), .drive_intrq_pin(drive_intrq_pin), .drive_rd_data(drive_rd_data),
    .run_work(run_work), .host_interrupt_out(host_interrupt_out), .block_resp_byte(block_resp_byte),
    .block_resp_strobe(block_resp_strobe), .drive_wr_strobe(), .drive_wr_data(),
    .drive_regs_direct(drive_regs_direct));

  engine_drive_model i_far (.sys_clk(sys_clk), .rst_b(rst_b), .run_work(run_work), .slow(slow),
    .fail(fail), .block_done(block_done), .block_resp_bits(block_resp_bits),
    .block_irq_enable(block_irq_enable), .inconsistency_evt(inconsistency_evt),
    .drive_err_pin(drive_err_pin), .drive_intrq_pin(drive_intrq_pin), .drive_rd_data(drive_rd_data));

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Cut a hang short well beyond the expected run length
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axw(input logic [11:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1;
    w = 1;
    @(posedge sys_clk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge sys_clk);
      if (aw && s_axi_awready) begin aw = 0; awvalid <= 0; end
      if (w && s_axi_wready) begin w = 0; wvalid <= 0; end
    end while (!s_axi_bvalid || aw || w);
    r = s_axi_bresp;
    bready <= 0;
  endtask

  task automatic axr(input logic [11:0] a);
    logic ar;
    ar = 1;
    @(posedge sys_clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge sys_clk);
      if (ar && s_axi_arready) begin ar = 0; arvalid <= 0; end
    end while (!s_axi_rvalid || ar);
    d = s_axi_rdata;
    r = s_axi_rresp;
    rready <= 0;
  endtask

  // Strobe then two cycles: state settles one cycle after the block ends
  task automatic wait_block();
    repeat (500) begin
      @(posedge sys_clk);
      if (block_resp_strobe) break;
    end
    chk(block_resp_strobe, 1);
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic t_reset();
    axr(`STAT_OFFS);
    chk(d[19:0], 20'h1000c);
    chk(drive_regs_direct, 1);
    axr(12'h010);
    chk(r, `AXI_SLVERR);
  endtask

  task automatic t_continuous();
    slow <= 1;
    // Count is loaded from the setting held before the go write
    axw(`CTRL_OFFS, 32'h0200);
    axw(`CTRL_OFFS, 32'h0201);
    axr(`STAT_OFFS);
    chk({d[19:16], d[15:8], d[3:1]}, {4'h4, 8'h02, 3'h0});
    wait_block();
    chk(block_resp_byte, 8'h01);
    wait_block();
    chk(host_interrupt_out, 1);
    axr(`STAT_OFFS);
    chk(d[19:0], 20'h20005);
    chk(host_interrupt_out, 0);
    axr(`DRV_OFFS);
    chk(d[7:0], `DRV_BUSY_VAL);
    axw(`CTRL_OFFS, 32'h0200);
    @(posedge sys_clk);
    chk(drive_regs_direct, 1);
    slow <= 0;
  endtask

  task automatic t_single_step();
    axw(`CTRL_OFFS, 32'h0203);
    wait_block();
    axr(`STAT_OFFS);
    chk(d[19:0], 20'h80103);
    wait_block();
    chk(block_resp_byte, 8'h01);
    axr(`STAT_OFFS);
    chk(d[19:16], 4'h2);
    axw(`CTRL_OFFS, 32'h0100);
  endtask

  task automatic t_bus_error();
    slow <= 1;
    axw(`CTRL_OFFS, 32'h0101);
    @(posedge sys_clk) bus_err <= 1;
    @(posedge sys_clk) bus_err <= 0;
    repeat (2) @(posedge sys_clk);
    chk({block_resp_strobe, block_resp_byte, host_interrupt_out}, {1'b0, 8'h01, 1'b1});
    axr(`STAT_OFFS);
    chk({d[19:16], d[6], d[4]}, {4'h1, 1'b1, 1'b0});
    slow <= 0;
  endtask

  task automatic t_error();
    fail <= 1;
    axw(`CTRL_OFFS, 32'h0101);
    wait_block();
    chk(block_resp_byte[7], 1);
    chk({drive_regs_direct, host_interrupt_out}, 2'b11);
    fail <= 0;
    axw(`CTRL_OFFS, 32'h0101);
    repeat (3) @(posedge sys_clk);
    chk(run_work, 0);
    axr(`STAT_OFFS);
    chk({d[19:16], d[4]}, {4'h1, 1'b1});
    axw(`CTRL_OFFS, 32'h0100);
    axr(`STAT_OFFS);
    chk(d[4], 0);
    axw(`CTRL_OFFS, 32'h0101);
    wait_block();
    chk({block_resp_byte, host_interrupt_out}, {8'h01, 1'b0});
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1;
    t_reset();
    t_continuous();
    t_single_step();
    t_bus_error();
    t_error();
    print_verdict();
  end
endmodule
`default_nettype wire
